// [src/io_bank_params.svh]
/*
  constants of the i/o control register bank: word indices,
  field positions, reset values and used-bit masks.
  assumes an includer that reads them by name only.
*/
// Contract
// - reading a flag register clears its flags
// - unused bits read zero, ignore writes
// - serial flag in bit 0, resets 0
// - port and key flags, reset 0
// - stopwatch 1 Hz and 10 Hz flags
// - tick 2, 8, 32 Hz flags, reset 0
// - tick 2/8/32 Hz enables, read/write, reset 0
// - output lines follow bits, reset high
// - frequency output on when bit 0 low
// - buzzer outputs on when bits low
// - direction and pull-up bits, reset 0
// - timer clear strobes, read back zero
// - stopwatch run bit, read/write, reset 0
// - heavy-load bit resets 1, fast variant 0
// - lcd static, blank-all, light-all controls
// - buzzer pitch select, reset 0
// - two-bit frequency output select, reset 0
`ifndef IO_BANK_PARAMS_SVH
`define IO_BANK_PARAMS_SVH
`define IX_SERIAL 10'h0EC
`define IX_PORT 10'h0ED
`define IX_SW 10'h0EE
`define IX_TICK 10'h0EF
`define IX_OUT 10'h0F3
`define IX_PDATA 10'h0F6
`define IX_TIMER 10'h0F9
`define IX_HEAVY 10'h0FA
`define IX_LCD 10'h0FB
`define IX_CFG 10'h0FC
`define IX_TONE 10'h0FD
`define IX_MSK0 10'h100
`define IX_MSK1 10'h101
`define IX_MSK2 10'h102
`define IX_MSK3 10'h103
`define VM_SERIAL 4'h1
`define VM_PORT 4'h3
`define VM_SW 4'h3
`define VM_TICK 4'h7
`define B_SW_CLR 0
`define B_SW_GO 1
`define B_TM_CLR 2
`define B_HEAVY 3
`define B_LCD_ON 1
`define B_LCD_OFF 2
`define B_LCD_STAT 3
`define B_DIR 0
`define B_PULL 1
`define B_PITCH 3
`define B_FSEL_HI 1
`define B_FSEL_LO 0
`define RST_OUT_LINE 4'hF
`define RST_LCD_OFF 1'b1
`define RST_HEAVY 1'b1
`endif

// [src/io_bank_pkg.sv]
/*
  types of the i/o control register bank: register select
  codes and the packed state record.
  assumes nothing of its surroundings.
*/
package io_bank_pkg;
  // register selected by the current bus address
  typedef enum logic [3:0] {
    SEL_NONE   = 4'h0,
    SEL_SERIAL = 4'h1,
    SEL_PORT   = 4'h2,
    SEL_SW     = 4'h3,
    SEL_TICK   = 4'h4,
    SEL_OUT    = 4'h5,
    SEL_PDATA  = 4'h6,
    SEL_TIMER  = 4'h7,
    SEL_HEAVY  = 4'h8,
    SEL_LCD    = 4'h9,
    SEL_CFG    = 4'hA,
    SEL_TONE   = 4'hB,
    SEL_MSK0   = 4'hC,
    SEL_MSK1   = 4'hD,
    SEL_MSK2   = 4'hE,
    SEL_MSK3   = 4'hF
  } reg_sel_e;

  // whole state of the bank
  typedef struct packed {
    logic [3:0][3:0] flag;
    logic [3:0][3:0] mask;
    logic [3:0]      out_line;
    logic [3:0]      pdata;
    logic            dir;
    logic            pull;
    logic            sw_go;
    logic            sw_clr;
    logic            tm_clr;
    logic            heavy;
    logic            lcd_stat;
    logic            lcd_off;
    logic            lcd_on;
    logic            pitch;
    logic [1:0]      fsel;
    logic [31:0]     rdata;
    logic            slverr;
  } bank_s;
endpackage : io_bank_pkg

// [src/io_control_register_bank.sv]
/*
  i/o control register bank: event flags with read-clear,
  enables, output port, bidirectional port, timer controls,
  lcd and tone controls, all behind an apb slave.
  assumes apb master on ref_clk_i and event inputs that are
  one-cycle pulses synchronous to the same clock.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "io_bank_params.svh"

module io_control_register_bank #(
  parameter bit HIGH_SPEED = 1'b0,
  parameter int AW         = 12
) (
  // clock, reset, enable
  input  wire logic          ref_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          ce_i,
  // apb slave
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  // event pulses from the peripherals
  input  wire logic          serial_evt_i,
  input  wire logic          pport_evt_i,
  input  wire logic          key_evt_i,
  input  wire logic          sw_1hz_evt_i,
  input  wire logic          sw_10hz_evt_i,
  input  wire logic          tick_2hz_evt_i,
  input  wire logic          tick_8hz_evt_i,
  input  wire logic          tick_32hz_evt_i,
  // output port and tone enables
  output logic      [3:0]    out_line_o,
  output logic               freq_out_on_o,
  output logic               tone_on_o,
  output logic               tone_inv_on_o,
  // bidirectional port
  input  wire logic [3:0]    bidir_line_i,
  output logic      [3:0]    bidir_line_o,
  output logic      [3:0]    bidir_line_oe_n_o,
  output logic               pullup_enable_o,
  // timer controls
  output logic               stopwatch_go_o,
  output logic               stopwatch_clear_o,
  output logic               tick_timer_clear_o,
  // mode, lcd and tone controls
  output logic               heavy_load_select_o,
  output logic               lcd_static_select_o,
  output logic               lcd_blank_all_o,
  output logic               lcd_light_all_o,
  output logic               tone_pitch_select_o,
  output logic      [1:0]    freq_out_sel_o,
  // interrupt
  output logic               irq_o
);

  // ****************************************************
  // parameter check
  // ****************************************************
  if (AW < 12)
  begin : g_bad_aw
    $error("address width too small for the bank");
  end

  // ****************************************************
  // functions
  // ****************************************************

  // word index to register select
  function automatic io_bank_pkg::reg_sel_e decode(
    input logic [9:0] ix
  );
    case (ix)
      `IX_SERIAL: decode = io_bank_pkg::SEL_SERIAL;
      `IX_PORT:   decode = io_bank_pkg::SEL_PORT;
      `IX_SW:     decode = io_bank_pkg::SEL_SW;
      `IX_TICK:   decode = io_bank_pkg::SEL_TICK;
      `IX_OUT:    decode = io_bank_pkg::SEL_OUT;
      `IX_PDATA:  decode = io_bank_pkg::SEL_PDATA;
      `IX_TIMER:  decode = io_bank_pkg::SEL_TIMER;
      `IX_HEAVY:  decode = io_bank_pkg::SEL_HEAVY;
      `IX_LCD:    decode = io_bank_pkg::SEL_LCD;
      `IX_CFG:    decode = io_bank_pkg::SEL_CFG;
      `IX_TONE:   decode = io_bank_pkg::SEL_TONE;
      `IX_MSK0:   decode = io_bank_pkg::SEL_MSK0;
      `IX_MSK1:   decode = io_bank_pkg::SEL_MSK1;
      `IX_MSK2:   decode = io_bank_pkg::SEL_MSK2;
      `IX_MSK3:   decode = io_bank_pkg::SEL_MSK3;
      default:    decode = io_bank_pkg::SEL_NONE;
    endcase
  endfunction : decode

  // used bits of flag slot k and its enable register
  function automatic logic [3:0] used_bits(
    input logic [1:0] k
  );
    case (k)
      2'h0:    used_bits = `VM_SERIAL;
      2'h1:    used_bits = `VM_PORT;
      2'h2:    used_bits = `VM_SW;
      default: used_bits = `VM_TICK;
    endcase
  endfunction : used_bits

  // ****************************************************
  // state and address decode
  // ****************************************************
  io_bank_pkg::bank_s   cur_ff;
  io_bank_pkg::bank_s   nxt_bank;
  io_bank_pkg::reg_sel_e sel;
  logic                 setup;
  logic                 acc;
  logic                 is_flag;
  logic                 is_mask;
  logic [1:0]           fk;
  logic [1:0]           mk;
  logic [3:0]           rd4;
  logic [3:0]           pin_or_data;
  logic [3:0][3:0]      ev;

  // bus phases and selected slot
  assign setup   = psel_i & ~penable_i;
  assign acc     = psel_i & penable_i;
  assign sel     = decode(paddr_i[11:2]);
  assign is_flag = (sel >= io_bank_pkg::SEL_SERIAL) &&
                   (sel <= io_bank_pkg::SEL_TICK);
  assign is_mask = (sel >= io_bank_pkg::SEL_MSK0);
  assign fk      = 2'(sel - io_bank_pkg::SEL_SERIAL);
  assign mk      = sel[1:0];

  // events gathered by flag register, unused bits zero
  assign ev[0] = {3'h0, serial_evt_i};
  assign ev[1] = {2'h0, pport_evt_i, key_evt_i};
  assign ev[2] = {2'h0, sw_1hz_evt_i, sw_10hz_evt_i};
  assign ev[3] = {1'b0, tick_2hz_evt_i, tick_8hz_evt_i, tick_32hz_evt_i};

  // port pins when input, latch when output
  assign pin_or_data = cur_ff.dir ? cur_ff.pdata : bidir_line_i;

  // ****************************************************
  // read word
  // ****************************************************

  // value of the selected register, unused bits zero
  always_comb
  begin
    rd4 = 4'h0;
    case (sel)
      io_bank_pkg::SEL_SERIAL, io_bank_pkg::SEL_PORT,
      io_bank_pkg::SEL_SW, io_bank_pkg::SEL_TICK:
        rd4 = cur_ff.flag[fk] & used_bits(fk);
      io_bank_pkg::SEL_OUT:
        rd4 = cur_ff.out_line;
      io_bank_pkg::SEL_PDATA:
        rd4 = pin_or_data;
      io_bank_pkg::SEL_TIMER:
        rd4[`B_SW_GO] = cur_ff.sw_go;
      io_bank_pkg::SEL_HEAVY:
        rd4[`B_HEAVY] = cur_ff.heavy;
      io_bank_pkg::SEL_LCD:
      begin
        rd4[`B_LCD_STAT] = cur_ff.lcd_stat;
        rd4[`B_LCD_OFF]  = cur_ff.lcd_off;
        rd4[`B_LCD_ON]   = cur_ff.lcd_on;
      end
      io_bank_pkg::SEL_CFG:
      begin
        rd4[`B_DIR]  = cur_ff.dir;
        rd4[`B_PULL] = cur_ff.pull;
      end
      io_bank_pkg::SEL_TONE:
      begin
        rd4[`B_PITCH] = cur_ff.pitch;
        rd4[`B_FSEL_HI:`B_FSEL_LO] = cur_ff.fsel;
      end
      io_bank_pkg::SEL_MSK0, io_bank_pkg::SEL_MSK1,
      io_bank_pkg::SEL_MSK2, io_bank_pkg::SEL_MSK3:
        rd4 = cur_ff.mask[mk];
      default: rd4 = 4'h0;
    endcase
  end

  // ****************************************************
  // next state
  // ****************************************************

  // bus side effects, then events on top
  always_comb
  begin
    nxt_bank = cur_ff;
    nxt_bank.sw_clr = 1'b0;
    nxt_bank.tm_clr = 1'b0;
    // capture read word in the setup cycle
    if (setup)
    begin
      nxt_bank.rdata  = {28'h0, rd4};
      nxt_bank.slverr = (sel == io_bank_pkg::SEL_NONE);
    end
    // read of a flag register clears what was read
    if (acc && !pwrite_i && is_flag)
    begin
      nxt_bank.flag[fk] = cur_ff.flag[fk] & ~cur_ff.rdata[3:0];
    end
    if (acc && pwrite_i)
    begin
      case (sel)
        io_bank_pkg::SEL_SERIAL, io_bank_pkg::SEL_PORT,
        io_bank_pkg::SEL_SW, io_bank_pkg::SEL_TICK:
          nxt_bank.flag[fk] = cur_ff.flag[fk] & ~pwdata_i[3:0];
        io_bank_pkg::SEL_OUT:
          nxt_bank.out_line = pwdata_i[3:0];
        io_bank_pkg::SEL_PDATA:
          nxt_bank.pdata = pwdata_i[3:0];
        io_bank_pkg::SEL_TIMER:
        begin
          nxt_bank.sw_clr = pwdata_i[`B_SW_CLR];
          nxt_bank.tm_clr = pwdata_i[`B_TM_CLR];
          nxt_bank.sw_go  = pwdata_i[`B_SW_GO];
        end
        io_bank_pkg::SEL_HEAVY:
          nxt_bank.heavy = pwdata_i[`B_HEAVY];
        io_bank_pkg::SEL_LCD:
        begin
          nxt_bank.lcd_stat = pwdata_i[`B_LCD_STAT];
          nxt_bank.lcd_off  = pwdata_i[`B_LCD_OFF];
          nxt_bank.lcd_on   = pwdata_i[`B_LCD_ON];
        end
        io_bank_pkg::SEL_CFG:
        begin
          nxt_bank.dir  = pwdata_i[`B_DIR];
          nxt_bank.pull = pwdata_i[`B_PULL];
        end
        io_bank_pkg::SEL_TONE:
        begin
          nxt_bank.pitch = pwdata_i[`B_PITCH];
          nxt_bank.fsel  = pwdata_i[`B_FSEL_HI:`B_FSEL_LO];
        end
        io_bank_pkg::SEL_MSK0, io_bank_pkg::SEL_MSK1,
        io_bank_pkg::SEL_MSK2, io_bank_pkg::SEL_MSK3:
          nxt_bank.mask[mk] = pwdata_i[3:0] & used_bits(mk);
        default: nxt_bank.pdata = cur_ff.pdata;
      endcase
    end
    // events set after any clear, so they win
    for (int k = 0; k < 4; k++)
    begin
      nxt_bank.flag[k] = nxt_bank.flag[k] | (ev[k] & used_bits(2'(k)));
    end
    // fast variant has no heavy-load mode
    if (HIGH_SPEED)
    begin
      nxt_bank.heavy = 1'b0;
    end
  end

  // state register, frozen while ce_i is low
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      cur_ff          <= '0;
      cur_ff.out_line <= `RST_OUT_LINE;
      cur_ff.lcd_off  <= `RST_LCD_OFF;
      cur_ff.heavy    <= HIGH_SPEED ? 1'b0 : `RST_HEAVY;
    end
    else if (ce_i)
    begin
      cur_ff <= nxt_bank;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************

  // bus answer, one access cycle unless frozen
  assign pready_o  = ce_i;
  assign prdata_o  = cur_ff.rdata;
  assign pslverr_o = cur_ff.slverr;

  // output port and active-low tone enables
  assign out_line_o    = cur_ff.out_line;
  assign freq_out_on_o = ~cur_ff.out_line[0];
  assign tone_on_o     = ~cur_ff.out_line[1];
  assign tone_inv_on_o = ~cur_ff.out_line[0];

  // bidirectional port drive
  assign bidir_line_o      = cur_ff.pdata;
  assign bidir_line_oe_n_o = {4{~cur_ff.dir}};
  assign pullup_enable_o   = cur_ff.pull;

  // timer, mode, lcd and tone controls
  assign stopwatch_go_o      = cur_ff.sw_go;
  assign stopwatch_clear_o   = cur_ff.sw_clr;
  assign tick_timer_clear_o  = cur_ff.tm_clr;
  assign heavy_load_select_o = cur_ff.heavy;
  assign lcd_static_select_o = cur_ff.lcd_stat;
  assign lcd_blank_all_o     = cur_ff.lcd_off;
  assign lcd_light_all_o     = cur_ff.lcd_on;
  assign tone_pitch_select_o = cur_ff.pitch;
  assign freq_out_sel_o      = cur_ff.fsel;

  // level interrupt from enabled flags
  assign irq_o = |(cur_ff.flag & cur_ff.mask);

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // completed bus accesses
  sequence s_rd_serial;
    ce_i && acc && !pwrite_i &&
    sel == io_bank_pkg::SEL_SERIAL && prdata_o[0] && !serial_evt_i;
  endsequence

  sequence s_wr_timer_clr;
    ce_i && acc && pwrite_i &&
    sel == io_bank_pkg::SEL_TIMER && pwdata_i[`B_SW_CLR];
  endsequence

  a_rd_clears_flag: assert property (
    s_rd_serial |=> !cur_ff.flag[0][0])
    else $error("serial flag not cleared by read");
  a_unused_zero: assert property (
    prdata_o[31:4] == 28'h0 &&
    ($past(setup && ce_i && sel == io_bank_pkg::SEL_SERIAL)
      -> prdata_o[3:1] == 3'h0))
    else $error("unused bits read non-zero");
  a_event_wins: assert property (
    ce_i && tick_2hz_evt_i |=> cur_ff.flag[3][2])
    else $error("tick event lost");
  a_irq_raise: assert property (
    ce_i && tick_32hz_evt_i && cur_ff.mask[3][0] |=> irq_o)
    else $error("enabled flag gave no interrupt");
  a_strobe_pulse: assert property (
    s_wr_timer_clr |=> stopwatch_clear_o ##1 !stopwatch_clear_o)
    else $error("stopwatch clear not a single pulse");
  a_run_written: assert property (
    ce_i && acc && pwrite_i && sel == io_bank_pkg::SEL_TIMER
    |=> stopwatch_go_o == $past(pwdata_i[`B_SW_GO]))
    else $error("run bit not written");
  a_reset_values: assert property (
    $past(sys_rst_i) |-> out_line_o == `RST_OUT_LINE &&
    lcd_blank_all_o && !lcd_light_all_o && !irq_o)
    else $error("wrong values after reset");
  a_heavy_fixed: assert property (
    HIGH_SPEED |-> !heavy_load_select_o)
    else $error("heavy-load set on fast variant");
  a_dir_drives: assert property (
    ce_i && acc && pwrite_i && sel == io_bank_pkg::SEL_CFG &&
    pwdata_i[`B_DIR] |=> bidir_line_oe_n_o == 4'h0)
    else $error("port not driven after direction write");

endmodule : io_control_register_bank
`default_nettype wire

// [test/io_control_register_bank_tb.sv]
/*
  self-checking bench of the i/o control register bank: apb tasks,
  event pulses and one task for each scenario.
  assumes the bank on one clock; ce_i stays high except in the
  freeze test, where it stretches one access.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_bank_params.svh"
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module io_control_register_bank_tb;
  // ******************************
  // signals
  // ******************************
  localparam int TIMEOUT_CYCLES = 5000;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  evt     = 8'h00;
  logic [3:0]  pins    = 4'hA;
  logic [3:0]  out_line, bidir_out, oe_n;
  logic [1:0]  fsel;
  logic        freq_on, tone_on, tone_inv_on, pull, sw_go, sw_clr, tm_clr;
  logic        heavy, lcd_stat, lcd_off, lcd_on, pitch, irq;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  // event source table: flag register and flag bit of each event
  logic [9:0]  evt_ix [8] = '{`IX_SERIAL, `IX_PORT, `IX_PORT, `IX_SW, `IX_SW,
                              `IX_TICK, `IX_TICK, `IX_TICK};
  logic [3:0]  evt_bit [8] = '{4'h1, 4'h2, 4'h1, 4'h2, 4'h1, 4'h4, 4'h2, 4'h1};

  // ******************************
  // design and clock
  // ******************************
  io_control_register_bank i_io_control_register_bank (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .serial_evt_i(evt[0]), .pport_evt_i(evt[1]), .key_evt_i(evt[2]),
    .sw_1hz_evt_i(evt[3]), .sw_10hz_evt_i(evt[4]), .tick_2hz_evt_i(evt[5]),
    .tick_8hz_evt_i(evt[6]), .tick_32hz_evt_i(evt[7]),
    .out_line_o(out_line), .freq_out_on_o(freq_on), .tone_on_o(tone_on),
    .tone_inv_on_o(tone_inv_on), .bidir_line_i(pins), .bidir_line_o(bidir_out),
    .bidir_line_oe_n_o(oe_n), .pullup_enable_o(pull), .stopwatch_go_o(sw_go),
    .stopwatch_clear_o(sw_clr), .tick_timer_clear_o(tm_clr),
    .heavy_load_select_o(heavy), .lcd_static_select_o(lcd_stat),
    .lcd_blank_all_o(lcd_off), .lcd_light_all_o(lcd_on),
    .tone_pitch_select_o(pitch), .freq_out_sel_o(fsel), .irq_o(irq)
  );

  // 25 mhz clock
  always #20 ref_clk = ~ref_clk;

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES)
    begin
      mismatches++;
      conclude();
    end
  end

  // ******************************
  // bus and event tasks
  // ******************************
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no timeout here; if pready never rises, only the hang guard ends this wait
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  // register write, upper data bits set to expose stray bits
  task automatic wr(input logic [9:0] ix, input logic [3:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, {ix, 2'b00}, {28'hFFFFFFF, v}, d, e);
  endtask : wr

  // register read compared with its expected word
  task automatic rd(input logic [9:0] ix, input logic [3:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, {ix, 2'b00}, 32'h0, d, e);
    `CHK({e, d}, {1'b0, 28'h0, exp})
  endtask : rd

  // one-cycle event pulse, then time for flag and irq to settle
  task automatic pulse(input int k);
    @(posedge ref_clk);
    evt <= 8'h01 << k;
    @(posedge ref_clk);
    evt <= 8'h00;
    @(posedge ref_clk);
    #1;
  endtask : pulse

  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    rd(`IX_SERIAL, 4'h0);
    rd(`IX_PORT, 4'h0);
    rd(`IX_SW, 4'h0);
    rd(`IX_TICK, 4'h0);
    rd(`IX_MSK3, 4'h0);
    rd(`IX_OUT, 4'hF);
    rd(`IX_PDATA, 4'hA);
    rd(`IX_TIMER, 4'h0);
    rd(`IX_HEAVY, 4'h8);
    rd(`IX_LCD, 4'h4);
    rd(`IX_CFG, 4'h0);
    rd(`IX_TONE, 4'h0);
    `CHK({out_line, freq_on, tone_on, tone_inv_on}, 7'h78)
    `CHK({heavy, lcd_stat, lcd_off, lcd_on, irq}, 5'h14)
    `CHK({oe_n, pull, sw_go, pitch, fsel}, 9'h1E0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_rw();
    wr(`IX_OUT, 4'h0);
    rd(`IX_OUT, 4'h0);
    `CHK({out_line, freq_on, tone_on, tone_inv_on}, 7'h07)
    wr(`IX_OUT, 4'h5);
    `CHK({out_line, freq_on, tone_on, tone_inv_on}, 7'h2A)
    wr(`IX_HEAVY, 4'hF);
    rd(`IX_HEAVY, 4'h8);
    wr(`IX_HEAVY, 4'h0);
    `CHK(heavy, 1'b0)
    wr(`IX_LCD, 4'hF);
    rd(`IX_LCD, 4'hE);
    `CHK({lcd_stat, lcd_off, lcd_on}, 3'h7)
    wr(`IX_TONE, 4'hF);
    rd(`IX_TONE, 4'hB);
    `CHK(pitch, 1'b1)
    for (int c = 0; c < 4; c++)
    begin
      wr(`IX_TONE, c[3:0]);
      `CHK(fsel, c[1:0])
    end
    wr(`IX_MSK3, 4'hF);
    rd(`IX_MSK3, 4'h7);
    wr(`IX_MSK3, 4'h0);
    $display("test read write done");
  endtask : t_rw

  task automatic t_bidir();
    @(posedge ref_clk);
    pins <= 4'h3;
    rd(`IX_PDATA, 4'h3);
    wr(`IX_PDATA, 4'h5);
    wr(`IX_CFG, 4'hF);
    rd(`IX_CFG, 4'h3);
    `CHK({oe_n, pull}, 5'h01)
    rd(`IX_PDATA, 4'h5);
    `CHK(bidir_out, 4'h5)
    wr(`IX_CFG, 4'h0);
    `CHK({oe_n, pull}, 5'h1E)
    $display("test bidir done");
  endtask : t_bidir

  task automatic t_timer();
    wr(`IX_TIMER, 4'hF);
    `CHK({sw_clr, tm_clr, sw_go}, 3'h7)
    @(posedge ref_clk);
    #1;
    `CHK({sw_clr, tm_clr, sw_go}, 3'h1)
    rd(`IX_TIMER, 4'h2);
    wr(`IX_TIMER, 4'h0);
    `CHK(sw_go, 1'b0)
    $display("test timer done");
  endtask : t_timer

  task automatic t_flags();
    for (int k = 0; k < 8; k++)
    begin
      pulse(k);
      `CHK(irq, 1'b0)
      rd(evt_ix[k], evt_bit[k]);
      rd(evt_ix[k], 4'h0);
    end
    $display("test flags done");
  endtask : t_flags

  task automatic t_irq();
    wr(`IX_MSK3, 4'h1);
    pulse(7);
    `CHK(irq, 1'b1)
    wr(`IX_MSK3, 4'h0);
    `CHK(irq, 1'b0)
    wr(`IX_MSK3, 4'h1);
    `CHK(irq, 1'b1)
    wr(`IX_TICK, 4'h1);
    `CHK(irq, 1'b0)
    wr(`IX_MSK0, 4'h1);
    pulse(0);
    `CHK(irq, 1'b1)
    rd(`IX_SERIAL, 4'h1);
    `CHK(irq, 1'b0)
    wr(`IX_MSK0, 4'h0);
    wr(`IX_MSK3, 4'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_race();
    pulse(6);
    fork
      rd(`IX_TICK, 4'h2);
      begin
        repeat (2) @(posedge ref_clk);
        evt <= 8'h40;
        @(posedge ref_clk);
        evt <= 8'h00;
      end
    join
    rd(`IX_TICK, 4'h2);
    rd(`IX_TICK, 4'h0);
    $display("test race done");
  endtask : t_race

  // enable low for two edges: access waits, events are dropped
  task automatic t_freeze();
    fork
      wr(`IX_PDATA, 4'h9);
      begin
        repeat (2) @(posedge ref_clk);
        ce  <= 1'b0;
        evt <= 8'h80;
        @(posedge ref_clk);
        #1;
        `CHK(pready, 1'b0)
        `CHK(bidir_out, 4'h5)
        @(posedge ref_clk);
        ce  <= 1'b1;
        evt <= 8'h00;
      end
    join
    `CHK(bidir_out, 4'h9)
    rd(`IX_TICK, 4'h0);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_unmapped();
    logic [31:0] d;
    logic        e;
    apb(1'b1, 12'h3C0, 32'hF, d, e);
    apb(1'b0, 12'h3C0, 32'h0, d, e);
    `CHK({e, d}, {1'b1, 32'h0})
    rd(`IX_CFG, 4'h0);
    $display("test unmapped done");
  endtask : t_unmapped

  // ******************************
  // closing and main sequence
  // ******************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_rw();
    t_bidir();
    t_timer();
    t_flags();
    t_irq();
    t_race();
    t_freeze();
    t_unmapped();
    conclude();
  end
endmodule : io_control_register_bank_tb
`default_nettype wire
